// *** rtl/phyreg_pkg.sv ***
`default_nettype none
package phyreg_pkg;
	localparam int          ADDR_W        = 5;
	localparam int          DATA_W        = 16;
	localparam logic [4:0]  A_CTRL_A      = 5'h00;
	localparam logic [4:0]  A_CTRL_B      = 5'h01;
	localparam logic [4:0]  A_IRQ_MASK    = 5'h02;
	localparam logic [4:0]  A_TX_BITS     = 5'h03;
	localparam logic [4:0]  A_BIT_COUNT   = 5'h04;
	localparam logic [4:0]  A_HOLE        = 5'h0a;
	localparam logic [4:0]  A_NOISE_MAX   = 5'h0d;
	localparam logic [4:0]  A_PORT_LOAD   = 5'h0e;
	localparam logic [4:0]  A_NOISE_LOAD  = 5'h0f;
	localparam logic [4:0]  A_STATUS_A    = 5'h10;
	localparam logic [4:0]  A_STATUS_B    = 5'h11;
	localparam logic [4:0]  A_PORT_TIMER  = 5'h12;
	localparam logic [4:0]  A_NOISE_TIMER = 5'h13;
	localparam logic [4:0]  A_CLK_DIV     = 5'h14;
	localparam logic [4:0]  A_SIGNATURE   = 5'h15;
	localparam logic [4:0]  A_RX_BITS     = 5'h16;
	localparam logic [4:0]  A_EVENTS      = 5'h17;
	localparam logic [4:0]  A_VIOL_CNT    = 5'h18;
	localparam logic [4:0]  A_IDLE_CNT    = 5'h19;
	localparam logic [4:0]  A_LINK_CNT    = 5'h1a;
	localparam logic [4:0]  A_LAST        = 5'h1a;
	// control register a fields
	localparam int          CA_NOISE_EN   = 14;
	localparam int          CA_NOISE_WIDE = 13;
	localparam int          CA_PORT_WIDE  = 12;
	localparam int          CA_SCRUB      = 11;
	localparam int          CA_VIOL_OVF   = 9;
	localparam int          CA_IDLE_OVF   = 8;
	localparam int          CA_LOOP       = 7;
	localparam logic [15:0] CA_RESET      = 16'h0000;
	localparam logic [15:0] CA_WMASK      = 16'h7bff;
	localparam logic [15:0] CA_RESTRICTED = 16'h3030;
	// event bits in the interrupt event register
	localparam int          EV_PROC_ERR   = 0;
	localparam int          EV_NOISE_TO   = 1;
	localparam int          EV_VIOL       = 2;
	localparam int          EV_IDLE_GAP   = 3;
	localparam int          EV_IDLE_MIN   = 4;
	// noise tick is 100 ns (80 ns rounded up to 2 mclk), counted every tick with CA_NOISE_WIDE, else every 4 ticks; mclk period 50 ns
	localparam int          SYM_NS        = 80;
	localparam int          CLK_NS        = 50;
	localparam int          TICK_CYC      = (SYM_NS + CLK_NS - 1) / CLK_NS;
	localparam int          NOISE_PRE_W   = 2;
	localparam int          PORT_PRE_W    = 8;
	localparam logic [2:0]  LS_NOISE      = 3'h0;
	localparam logic [2:0]  LS_ACTIVE     = 3'h1;
	localparam logic [2:0]  LS_IDLE4      = 3'h3;
	localparam logic [2:0]  LS_IDLE16     = 3'h7;
	localparam logic [4:0]  SYM_IDLE      = 5'h1f;
	localparam logic [15:0] RD_NONE       = 16'h0000;

	typedef enum logic [3:0] {
		PHYREG_IDLE  = 4'b0001,
		PHYREG_WAIT  = 4'b0010,
		PHYREG_HOLD  = 4'b0100,
		PHYREG_DONE  = 4'b1000
	} phyreg_bus_t;

	typedef struct packed {
		logic              maintenance_state;
		logic              off_state;
		logic              signalling_active_flag;
		logic              config_override;
		logic [2:0]        line_state;
		logic              unknown_line;
		logic [4:0]        maintenance_line_state;
		logic              violation_count_event;
		logic              idle_gap_count_event;
		logic              idle_min_event;
		logic              link_error_event;
		logic [15:0]       status_a;
		logic [15:0]       status_b;
		logic [15:0]       rx_bits;
		logic [15:0]       signature;
	} phyreg_core_t;
endpackage
`default_nettype wire

// *** rtl/phyreg_bank.sv ***
`default_nettype none
module phyreg_bank
	import phyreg_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               rstn,
	input  wire logic               cs_n,
	input  wire logic               rw,
	input  wire logic [4:0]         addr,
	input  wire logic [15:0]        wdata_in,
	output var  logic [15:0]        rdata_out,
	output var  logic               rdata_oe,
	input  wire phyreg_core_t       core,
	input  wire logic [4:0]         receive_symbol_in,
	input  wire logic [4:0]         transmit_symbol_in,
	output var  logic [4:0]         receive_symbol_output,
	output var  logic [4:0]         transmit_symbol_output,
	output var  logic               external_loop_pin_n,
	output var  logic [15:0]        control_b_out,
	output var  logic [15:0]        irq_mask_out
);
	typedef struct packed {
		logic [2:0]  cs_s;
		logic [2:0]  rw_s;
		phyreg_bus_t st;
		logic [4:0]  a;
		logic        wr;
		logic [15:0] rdata;
		logic        oe;
		logic [15:0] ctrl_a;
		logic [15:0] ctrl_b;
		logic [15:0] mask;
		logic [13:1][15:0] cfg;
		logic [15:0] port_tmr;
		logic [15:0] noise_tmr;
		logic [PORT_PRE_W-1:0]  port_pre;
		logic [NOISE_PRE_W-1:0] noise_pre;
		logic [1:0]  tick_cnt;
		logic        noise_run;
		logic [2:0]  ls_q;
		logic [15:0] events;
		logic [15:0] viol_cnt;
		logic [15:0] idle_cnt;
		logic [15:0] link_cnt;
		logic [4:0]  rx_sym;
		logic [4:0]  tx_sym;
		logic        loop_n;
	} phyreg_state_t;

	phyreg_state_t s_q, s_d;

	function automatic logic is_idle(input logic [2:0] ls);
		is_idle = (ls == LS_IDLE4) || (ls == LS_IDLE16);
	endfunction

	function automatic logic rd_clears(input logic [4:0] a);
		rd_clears = (a >= A_EVENTS) && (a <= A_LAST);
	endfunction

	logic rw_now;
	logic tick, noise_step, port_step, maintenance_state_cfg, off_maintenance_state;
	logic wr_ok, last_idle, now_idle;
	logic [15:0] cin, rd;

	assign rw_now  = s_q.rw_s[2];
	assign maintenance_state_cfg = core.maintenance_state | core.config_override;
	assign off_maintenance_state = core.maintenance_state | core.off_state;

	always_comb begin
		rd = RD_NONE;
		case (s_q.a)
			A_CTRL_A:      rd = s_q.ctrl_a & CA_WMASK;
			A_CTRL_B:      rd = s_q.ctrl_b;
			A_IRQ_MASK:    rd = s_q.mask;
			A_STATUS_A:    rd = core.status_a;
			A_STATUS_B:    rd = core.status_b;
			A_PORT_TIMER:  rd = s_q.port_tmr;
			A_NOISE_TIMER: rd = s_q.noise_tmr;
			A_CLK_DIV:     rd = {8'h00, s_q.port_pre};
			A_SIGNATURE:   rd = core.signature;
			A_RX_BITS:     rd = core.rx_bits;
			A_EVENTS:      rd = s_q.events;
			A_VIOL_CNT:    rd = s_q.viol_cnt;
			A_IDLE_CNT:    rd = s_q.idle_cnt;
			A_LINK_CNT:    rd = s_q.link_cnt;
			default: begin
				if (s_q.a > A_CTRL_B && s_q.a < A_PORT_LOAD
					&& s_q.a != A_HOLE) begin
					rd = s_q.cfg[4'(s_q.a)];
				end
			end
		endcase
	end

	always_comb begin
		s_d = s_q;
		cin = wdata_in;
		wr_ok = 1'b0;
		s_d.cs_s = {s_q.cs_s[1:0], ~cs_n};
		s_d.rw_s = {s_q.rw_s[1:0], rw};
		// bus walk: take address, then act one edge later
		case (s_q.st)
			PHYREG_IDLE: begin
				if (s_q.cs_s[2] && s_q.cs_s[1]) begin
					s_d.a  = addr;
					s_d.wr = ~rw_now;
					s_d.st = PHYREG_WAIT;
					s_d.oe = 1'b0;
				end
			end
			PHYREG_WAIT: begin
				if (s_q.wr) begin
					s_d.st = PHYREG_DONE;
					if (s_q.a == A_CTRL_A) begin
						// restricted bits kept outside off/maintenance_state
						if (off_maintenance_state) begin
							s_d.ctrl_a = cin & CA_WMASK;
						end else begin
							s_d.ctrl_a = (cin & CA_WMASK & ~CA_RESTRICTED
								& ~16'h6000)
								| (s_q.ctrl_a & (CA_RESTRICTED | 16'h3000));
							s_d.ctrl_a[CA_NOISE_EN] = cin[CA_NOISE_EN];
						end
						wr_ok = 1'b1;
					end else if (s_q.a == A_CTRL_B) begin
						s_d.ctrl_b = cin;
						wr_ok = 1'b1;
					end else if (s_q.a == A_IRQ_MASK) begin
						s_d.mask = cin;
						wr_ok = 1'b1;
					end else if (s_q.a == A_TX_BITS || s_q.a == A_BIT_COUNT) begin
						wr_ok = ~core.signalling_active_flag;
					end else if (s_q.a > A_BIT_COUNT && s_q.a < A_PORT_LOAD
						&& s_q.a != A_HOLE) begin
						wr_ok = 1'b1;
					end else if (s_q.a == A_PORT_LOAD) begin
						wr_ok = core.maintenance_state;
						if (wr_ok) begin
							s_d.port_tmr = cin;
						end
					end else if (s_q.a == A_NOISE_LOAD) begin
						wr_ok = core.maintenance_state
							& ~s_q.ctrl_a[CA_NOISE_EN];
						if (wr_ok) begin
							s_d.noise_tmr = cin;
						end
					end
					if (wr_ok && s_q.a > A_CTRL_B && s_q.a < A_PORT_LOAD) begin
						s_d.cfg[4'(s_q.a)] = cin;
					end
					if (!wr_ok) begin
						s_d.events[EV_PROC_ERR] = 1'b1;
					end
				end else begin
					s_d.rdata = rd;
					// enable rises with the data, never ahead of it
					s_d.oe = 1'b1;
					s_d.st = PHYREG_HOLD;
					if (rd_clears(s_q.a)) begin
						case (s_q.a)
							A_EVENTS:   s_d.events = 16'h0000;
							A_VIOL_CNT: s_d.viol_cnt = 16'h0000;
							A_IDLE_CNT: s_d.idle_cnt = 16'h0000;
							default:    s_d.link_cnt = 16'h0000;
						endcase
					end
				end
			end
			PHYREG_HOLD: begin
				// held select repeats the read every two edges
				s_d.st = s_q.cs_s[2] ? PHYREG_WAIT : PHYREG_DONE;
				if (s_q.cs_s[2]) begin
					s_d.wr = 1'b0;
				end
			end
			PHYREG_DONE: begin
				s_d.oe = 1'b0;
				if (!s_q.cs_s[2] && !s_q.cs_s[1]) begin
					s_d.st = PHYREG_IDLE; // one write per select
				end
			end
			default: s_d.st = PHYREG_IDLE;
		endcase
		// 80 ns tick from 50 ns clock, rounded up
		tick = (s_q.tick_cnt == 2'(TICK_CYC - 1));
		s_d.tick_cnt = tick ? 2'h0 : s_q.tick_cnt + 2'h1;
		noise_step = tick && (s_q.ctrl_a[CA_NOISE_WIDE]
			|| s_q.noise_pre == '1);
		port_step = tick && (s_q.ctrl_a[CA_PORT_WIDE]
			|| s_q.port_pre == '1);
		if (tick) begin
			s_d.noise_pre = s_q.noise_pre + 1'b1;
			s_d.port_pre  = s_q.port_pre + 1'b1;
		end
		if (port_step && s_d.port_tmr == s_q.port_tmr) begin
			s_d.port_tmr = s_q.port_tmr + 16'h0001;
		end
		// noise timing: up-count from max load to expiry at wrap
		s_d.ls_q = core.line_state;
		last_idle = is_idle(s_q.ls_q);
		now_idle  = is_idle(core.line_state);
		if (core.maintenance_state && s_q.ctrl_a[CA_NOISE_EN]) begin
			if (last_idle && (!now_idle || core.unknown_line)) begin
				s_d.noise_tmr = s_q.cfg[4'(A_NOISE_MAX)];
				s_d.noise_run = 1'b1;
			end else if (now_idle) begin
				s_d.noise_run = 1'b0;
			end else if (s_q.noise_run && noise_step) begin
				s_d.noise_tmr = s_q.noise_tmr + 16'h0001;
				if (s_q.noise_tmr == 16'hffff) begin
					s_d.events[EV_NOISE_TO] = 1'b1;
					s_d.noise_run = 1'b0;
				end
			end
		end else begin
			s_d.noise_run = 1'b0;
		end
		// counters; events set after any clear so set wins
		if (core.violation_count_event) begin
			s_d.viol_cnt = s_d.viol_cnt + 16'h0001;
			if (!s_q.ctrl_a[CA_VIOL_OVF] || s_d.viol_cnt[7:0] == 8'h00) begin
				s_d.events[EV_VIOL] = 1'b1;
			end
		end
		if (core.idle_gap_count_event) begin
			s_d.idle_cnt[3:0] = s_d.idle_cnt[3:0] + 4'h1;
			if (!s_q.ctrl_a[CA_IDLE_OVF] || s_d.idle_cnt[3:0] == 4'h0) begin
				s_d.events[EV_IDLE_GAP] = 1'b1;
			end
		end
		if (core.idle_min_event) begin
			s_d.events[EV_IDLE_MIN] = 1'b1;
		end
		if (core.link_error_event) begin
			s_d.link_cnt = s_d.link_cnt + 16'h0001;
		end
		// scrub only steers the receive side
		s_d.rx_sym = (maintenance_state_cfg && s_q.ctrl_a[CA_SCRUB]) ? SYM_IDLE
			: receive_symbol_in;
		s_d.tx_sym = core.maintenance_state ? core.maintenance_line_state
			: transmit_symbol_in;
		s_d.loop_n = ~s_q.ctrl_a[CA_LOOP];
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.st <= PHYREG_IDLE;
			s_q.ctrl_a <= CA_RESET;
			s_q.loop_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_out              = s_q.rdata;
	assign rdata_oe               = s_q.oe;
	assign receive_symbol_output  = s_q.rx_sym;
	assign transmit_symbol_output = s_q.tx_sym;
	assign external_loop_pin_n    = s_q.loop_n;
	assign control_b_out          = s_q.ctrl_b;
	assign irq_mask_out           = s_q.mask;
endmodule
`default_nettype wire

// *** test/phyreg_sva.sv ***
`default_nettype none
module phyreg_sva
	import phyreg_pkg::*;
(
	input wire logic         mclk,
	input wire logic         rstn,
	input wire logic         cs_n,
	input wire logic         rw,
	input wire logic [4:0]   addr,
	input wire logic [15:0]  rdata_out,
	input wire logic         rdata_oe,
	input wire phyreg_core_t core,
	input wire logic [4:0]   receive_symbol_in,
	input wire logic [4:0]   receive_symbol_output,
	input wire logic [4:0]   transmit_symbol_output,
	input wire logic         external_loop_pin_n
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence s_rd_go;
		$fell(cs_n) && rw;
	endsequence
	sequence s_rd_up;
		##[2:10] rdata_oe;
	endsequence
	a_read_answer: assert property (s_rd_go |-> s_rd_up)
		else $error("read not answered");
	a_oe_late: assert property ($rose(rdata_oe) |-> $past(!cs_n, 2))
		else $error("bus driven too early");
	a_oe_drops: assert property ($rose(cs_n) |-> ##[1:8] !rdata_oe)
		else $error("bus not released");
	a_oe_read_only: assert property (rdata_oe |-> rw)
		else $error("bus driven in write");
	a_hole_zero: assert property (!cs_n && rdata_oe && addr == A_HOLE
		|-> rdata_out == RD_NONE)
		else $error("unmapped read not zero");
	a_resv_zero: assert property (!cs_n && rdata_oe && addr == A_CTRL_A
		|-> !rdata_out[15] && !rdata_out[10])
		else $error("reserved bit set");
	a_loop_by_write: assert property ($changed(external_loop_pin_n)
		|-> $past(!cs_n && !rw, 2))
		else $error("loop pin moved without write");
	a_tx_maintenance_state: assert property ($past(rstn) && $past(core.maintenance_state)
		|-> transmit_symbol_output == $past(core.maintenance_line_state))
		else $error("transmit not line state");
	a_rx_plain: assert property ($past(rstn) && !$past(core.maintenance_state)
		&& !$past(core.config_override)
		|-> receive_symbol_output == $past(receive_symbol_in))
		else $error("scrub active outside its states");
	a_rx_source: assert property ($past(rstn) |-> receive_symbol_output
		== $past(receive_symbol_in) || receive_symbol_output == SYM_IDLE)
		else $error("receive output of unknown source");
endmodule
bind phyreg_bank phyreg_sva u_sva (.mclk(mclk), .rstn(rstn), .cs_n(cs_n),
	.rw(rw), .addr(addr), .rdata_out(rdata_out), .rdata_oe(rdata_oe),
	.core(core), .receive_symbol_in(receive_symbol_in),
	.receive_symbol_output(receive_symbol_output),
	.transmit_symbol_output(transmit_symbol_output),
	.external_loop_pin_n(external_loop_pin_n));
`default_nettype wire

// *** test/phyreg_npm.sv ***
`default_nettype none
module phyreg_npm
	import phyreg_pkg::*;
(
	input  wire logic        mclk,
	output var  logic        cs_n,
	output var  logic        rw,
	output var  logic [4:0]  addr,
	output var  logic [15:0] wdata,
	input  wire logic [15:0] rdata,
	input  wire logic        oe
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cs_n = 1'h1;
		rw = 1'h1;
		addr = 5'h00;
		wdata = 16'h0000;
	end
	// select held long past the write edge; one write per select
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk);
		cs_n <= 1'h0;
		rw <= 1'h0;
		addr <= a;
		wdata <= d;
		repeat (8) @(posedge mclk);
		cs_n <= 1'h1;
		rw <= 1'h1;
		wdata <= ~d;
		repeat (6) @(posedge mclk);
	endtask
	// data taken on first drive: a held select re-reads and clears again
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		cs_n <= 1'h0;
		rw <= 1'h1;
		addr <= a;
		do @(posedge mclk); while (oe !== 1'h1 && ++n < 20);
		d = (oe === 1'h1) ? rdata : 16'hxxxx;
		cs_n <= 1'h1;
		do @(posedge mclk); while (oe !== 1'h0 && ++n < 40);
		repeat (2) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
	n_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench
	import phyreg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic         mclk = 1'h0;
	logic         rstn = 1'h0;
	logic         cs_n, rw, oe, lp;
	logic [4:0]   addr, rxo, txo;
	logic [4:0]   rxi = 5'h0a;
	logic [4:0]   txi = 5'h15;
	logic [15:0]  wd, rdo, cb, mk, v;
	phyreg_core_t core;
	int           n_errors = 0;
	int           total_checks = 0;
	int           cyc = 0;
	logic [4:0]   bad [5] = '{A_TX_BITS, A_PORT_LOAD, A_NOISE_LOAD,
		A_STATUS_A, A_HOLE};
	always #25 mclk = ~mclk;
	phyreg_npm u_np (.mclk(mclk), .cs_n(cs_n), .rw(rw), .addr(addr),
		.wdata(wd), .rdata(rdo), .oe(oe));
	phyreg_bank dut (.mclk(mclk), .rstn(rstn), .cs_n(cs_n), .rw(rw),
		.addr(addr), .wdata_in(wd), .rdata_out(rdo), .rdata_oe(oe),
		.core(core), .receive_symbol_in(rxi), .transmit_symbol_in(txi),
		.receive_symbol_output(rxo), .transmit_symbol_output(txo),
		.external_loop_pin_n(lp), .control_b_out(cb), .irq_mask_out(mk));
	task automatic final_report;
		if (n_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk_rd(input logic [4:0] a, input logic [15:0] e,
		input string nm);
		u_np.rd(a, v);
		`CHK(nm, e, v)
	endtask
	// one-cycle pulses from the counter logic
	task automatic ev(input logic vi, gi, mi);
		@(posedge mclk);
		core.violation_count_event <= vi;
		core.idle_gap_count_event <= gi;
		core.idle_min_event <= mi;
		@(posedge mclk);
		core.violation_count_event <= 1'h0;
		core.idle_gap_count_event <= 1'h0;
		core.idle_min_event <= 1'h0;
		repeat (3) @(posedge mclk);
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_errors++;
			final_report;
		end
	end
	initial begin
		core = '0;
		core.line_state = LS_IDLE16;
		core.maintenance_line_state = 5'h0c;
		repeat (12) @(posedge mclk);
		rstn <= 1'h1;
		chk_rd(A_CTRL_A, 16'h0000, "ctrl_a_reset");
		`CHK("loop_pin_reset", 1'h1, lp)
		@(posedge mclk) core.maintenance_state <= 1'h1;
		u_np.wr(A_CTRL_A, 16'hfb80);
		chk_rd(A_CTRL_A, 16'h7b80, "ctrl_a_maintenance_state");
		`CHK("loop_pin", 1'h0, lp)
		`CHK("rx_scrub", SYM_IDLE, rxo)
		`CHK("tx_maintenance_state", 5'h0c, txo)
		ev(1'h1, 1'h1, 1'h1);
		chk_rd(A_EVENTS, 16'h0010, "ev_ovf_mode");
		u_np.wr(A_CTRL_A, 16'h4880);
		ev(1'h1, 1'h1, 1'h0);
		chk_rd(A_EVENTS, 16'h000c, "ev_each");
		chk_rd(A_EVENTS, 16'h0000, "ev_cleared");
		u_np.wr(A_PORT_LOAD, 16'h0100);
		u_np.wr(A_NOISE_LOAD, 16'h0100);
		chk_rd(A_EVENTS, 16'h0001, "ev_load");
		u_np.wr(A_CTRL_A, 16'h3030);
		@(posedge mclk) core.maintenance_state <= 1'h0;
		u_np.wr(A_CTRL_A, 16'h0800);
		chk_rd(A_CTRL_A, 16'h3830, "ctrl_a_held");
		`CHK("rx_pass", rxi, rxo)
		@(posedge mclk) core.config_override <= 1'h1;
		repeat (3) @(negedge mclk);
		`CHK("rx_override", SYM_IDLE, rxo)
		@(posedge mclk) core.config_override <= 1'h0;
		u_np.wr(A_TX_BITS, 16'h1234);
		@(posedge mclk) core.signalling_active_flag <= 1'h1;
		foreach (bad[i]) begin
			u_np.wr(bad[i], 16'hffff);
			chk_rd(A_EVENTS, 16'h0001, "ev_illegal");
		end
		chk_rd(A_TX_BITS, 16'h1234, "tx_bits_locked");
		chk_rd(A_HOLE, 16'h0000, "hole");
		for (int a = 5; a <= 13; a++) begin
			if (a != 10) begin
				u_np.wr(5'(a), 16'(a * 257));
				chk_rd(5'(a), 16'(a * 257), "rw_reg");
			end
		end
		u_np.wr(A_CTRL_B, 16'h00a5);
		`CHK("ctrl_b_out", 16'h00a5, cb)
		u_np.wr(A_IRQ_MASK, 16'h5a00);
		`CHK("irq_mask_out", 16'h5a00, mk)
		final_report;
	end
endmodule
`default_nettype wire
